// ---- pkg/csc_pkg.sv ----
package csc_pkg;
    localparam int APB_AW = 12;
    localparam int PIX_W = 8;
    localparam int COEF_W = 8;
    localparam int COEF_FRAC = 5;
    localparam int NUM_COMP = 4;
    localparam int NUM_PAIR = 8;
    // Register byte offsets
    localparam logic [APB_AW-1:0] CTL_OFS = 12'h000;
    localparam logic [APB_AW-1:0] PAIR0_OFS = 12'h004;
    localparam logic [APB_AW-1:0] PAIR_STRIDE = 12'h004;
    localparam int EN_POS = 0;
    localparam int LO_LSB = 0;
    localparam int HI_LSB = 8;
    localparam logic [31:0] CTL_RST = 32'h0000_0000;
    localparam logic [15:0] PAIR_RST = 16'h0000;
    localparam logic [PIX_W-1:0] PIX_MAX = 8'hFF;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic [PIX_W-1:0] c3;
        logic [PIX_W-1:0] c2;
        logic [PIX_W-1:0] c1;
        logic [PIX_W-1:0] c0;
    } csc_pix_s;

    typedef struct packed {
        logic [APB_AW-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } csc_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } csc_apb_rsp_s;
endpackage : csc_pkg

// ---- tb/csc_matrix_props.sv ----
`timescale 1ns/1ps
module csc_matrix_props (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset
    input wire csc_pkg::csc_apb_req_s apb_req, // Request
    input wire csc_pkg::csc_apb_rsp_s apb_rsp, // Response
    input wire csc_pkg::csc_pix_s pix_in, // Pixel in
    input wire logic pix_in_valid, // In valid
    input wire logic pix_in_ready, // In ready
    input wire csc_pkg::csc_pix_s pix_out, // Pixel out
    input wire logic pix_out_valid, // Out valid
    input wire logic pix_out_ready // Out ready
);
    import csc_pkg::*;
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd, wr;
    logic [15:0] wd_r;
    assign rd = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wd_r <= 16'h0000;
        else if (wr)
            wd_r <= apb_req.pwdata[15:0];
    end
    sequence s_take; pix_in_valid && pix_in_ready; endsequence
    sequence s_wr0; wr && apb_req.paddr == PAIR0_OFS; endsequence
    sequence s_rd0; rd && apb_req.paddr == PAIR0_OFS; endsequence
    chk_reset_values: assert property ($rose(presetn) |-> apb_rsp.prdata == 0 && !pix_out_valid)
        else $error("state not clear after reset");
    chk_ctl_upper: assert property (rd && apb_req.paddr == CTL_OFS |=> apb_rsp.prdata[31:1] == 0)
        else $error("control upper bits set");
    chk_pair_upper: assert property (rd |=> apb_rsp.prdata[31:16] == 16'h0000)
        else $error("upper half not zero");
    chk_unmapped_zero: assert property (rd && apb_req.paddr > PAIR0_OFS + 7 * PAIR_STRIDE |=> apb_rsp.prdata == 0)
        else $error("unmapped read not zero");
    chk_pair_readback: assert property (s_wr0 ##[1:2] s_rd0 |=> apb_rsp.prdata == {16'h0000, wd_r})
        else $error("pair readback differs");
    chk_out_hold: assert property (pix_out_valid && !pix_out_ready |=> pix_out_valid && $stable(pix_out))
        else $error("stalled output changed");
    chk_pix_latency: assert property (s_take |-> ##[1:2] pix_out_valid)
        else $error("output late");
    chk_in_refuse: assert property (!pix_in_ready |-> pix_out_valid)
        else $error("refused while empty");
    chk_no_slverr: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready && !apb_rsp.pslverr)
        else $error("access not completed cleanly");
endmodule : csc_matrix_props

bind csc_matrix csc_matrix_props u_csc_matrix_props (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .pix_in(pix_in), .pix_in_valid(pix_in_valid),
    .pix_in_ready(pix_in_ready), .pix_out(pix_out), .pix_out_valid(pix_out_valid),
    .pix_out_ready(pix_out_ready));

// ---- tb/tb_csc_matrix.sv ----
`timescale 1ns/1ps
module tb_csc_matrix;
    import csc_pkg::*;
    logic pclk = 0, presetn = 0, in_vld = 0, out_rdy = 0, in_rdy, out_vld;
    csc_apb_req_s req = '0;
    csc_apb_rsp_s rsp;
    csc_pix_s pin = '0, pout;
    logic [7:0] cf [16];
    logic [31:0] q, exp_q [$];
    logic [31:0] px [3] = '{32'hFF204080, 32'h00FF0010, 32'h7F7F7F7F};
    int errors = 0, checks_done = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    csc_matrix u_csc_matrix (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
        .pix_in(pin), .pix_in_valid(in_vld), .pix_in_ready(in_rdy), .pix_out(pout),
        .pix_out_valid(out_vld), .pix_out_ready(out_rdy));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        do @(posedge pclk); while (rsp.pready !== 1'b1);
        q = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    task automatic push(input logic [31:0] p, input logic [31:0] e);
        @(posedge pclk);
        pin <= p;
        in_vld <= 1'b1;
        do @(posedge pclk); while (in_rdy !== 1'b1);
        in_vld <= 1'b0;
        exp_q.push_back(e);
    endtask : push
    task automatic drain();
        out_rdy <= 1'b1;
        while (exp_q.size() > 0) begin
            do @(posedge pclk); while (out_vld !== 1'b1);
            chk("pixel", pout, exp_q.pop_front());
        end
        out_rdy <= 1'b0;
    endtask : drain
    // Row sums, floored and clamped to 0..255
    function automatic logic [31:0] cv(input logic [31:0] p);
        int s;
        cv = '0;
        for (int r = 0; r < 4; r++) begin
            s = 0;
            for (int c = 0; c < 4; c++) s += $signed(cf[4*r+c]) * int'(p[8*c+:8]);
            s = s >>> 5;
            cv[8*r+:8] = s < 0 ? 8'h00 : s > 255 ? 8'hFF : s[7:0];
        end
    endfunction : cv
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            apb(1'b0, 12'(4 * a), '0);
            chk("reset", q, '0);
        end
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 12'(PAIR0_OFS + PAIR_STRIDE * k), 32'h0000_FF80 + k);
            apb(1'b0, 12'(PAIR0_OFS + PAIR_STRIDE * k), '0);
            chk("pair", q, 32'h0000_FF80 + k);
        end
        apb(1'b1, 12'h024, 32'h0000_00AA);
        apb(1'b0, 12'h024, '0);
        chk("unmapped", q, '0);
        apb(1'b1, CTL_OFS, 32'h1);
        apb(1'b0, CTL_OFS, '0);
        chk("ctl", q, 32'h1);
        for (int i = 0; i < 16; i++) cf[i] = i % 5 == 0 ? 8'h30 : 8'hF8;
        for (int k = 0; k < 8; k++) apb(1'b1, 12'(PAIR0_OFS + PAIR_STRIDE * k),
            {16'h0000, cf[2*k+1], cf[2*k]});
        apb(1'b1, CTL_OFS, '0);
        $display("test registers done");
        foreach (px[i]) push(px[i], px[i]);
        @(negedge pclk);
        chk("full", in_rdy, '0);
        @(posedge pclk);
        drain();
        $display("test bypass done");
        apb(1'b1, CTL_OFS, 32'h1);
        foreach (px[i]) push(px[i], cv(px[i]));
        drain();
        $display("test convert done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTL_OFS, '0);
        chk("ctl after reset", q, '0);
        apb(1'b0, PAIR0_OFS, '0);
        chk("pair after reset", q, '0);
        $display("test reset done");
        summarize();
    end
endmodule : tb_csc_matrix

// ---- verilog/csc_matrix.sv ----
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
// Behaviour
// RQ1 - Bit 0 of control register off disables, on enables conversion.
// RQ2 - Coefficients are signed 8-bit values with five fractional bits.
// RQ3 - Even column coefficient in bits 7-0, odd column in bits 15-8.
// RQ4 - Sixteen coefficients form 4x4 matrix, two per register, eight registers.
// RQ5 - Every coefficient field stores any 8-bit value and reads it back.
// RQ6 - After reset enable and all coefficients read zero.
// RQ7 - Software writes zeros to unused upper bits; device reads them zero.
// RQ8 - Enabled output is row dot product scaled; disabled passes input through.
module csc_matrix
    import csc_pkg::*;
(
    input wire logic pclk, // Clock, 200 MHz
    input wire logic presetn, // Async reset, active low
    input wire csc_pkg::csc_apb_req_s apb_req, // APB request group
    output csc_pkg::csc_apb_rsp_s apb_rsp, // APB response group
    input wire csc_pkg::csc_pix_s pix_in, // Input pixel components
    input wire logic pix_in_valid, // Input pixel valid
    output logic pix_in_ready, // Converter accepts input
    output csc_pkg::csc_pix_s pix_out, // Output pixel components
    output logic pix_out_valid, // Output pixel valid
    input wire logic pix_out_ready // Downstream accepts output
);
    import csc_pkg::*;

    logic color_convert_on_r;
    logic [COEF_W-1:0] coef_r [NUM_COMP][NUM_COMP];
    logic [31:0] prdata_r;
    csc_pix_s res_r;
    logic res_valid_r;
    logic buf_in_ready;
    logic wr_en;
    logic rd_en;
    logic stage_ready;
    logic [3:0] rd_pair;
    logic [31:0] rd_word;
    logic [PIX_W-1:0] conv_c [NUM_COMP];

    // Index of coefficient pair register, or NUM_PAIR when not a pair
    function automatic logic [3:0] pair_index(input logic [APB_AW-1:0] addr);
        logic [3:0] idx;
        idx = 4'(NUM_PAIR);
        for (int k = 0; k < NUM_PAIR; k++) begin
            if (addr == APB_AW'(PAIR0_OFS + APB_AW'(k) * PAIR_STRIDE)) begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction : pair_index

    // Clamp a Q5-scaled signed sum into the unsigned pixel range
    function automatic logic [PIX_W-1:0] clamp_pix(input logic signed [19:0] acc);
        logic signed [19:0] sh;
        sh = acc >>> COEF_FRAC;
        if (sh < 0) begin
            return '0;
        end else if (sh > 20'sd255) begin
            return PIX_MAX;
        end
        return sh[PIX_W-1:0];
    endfunction : clamp_pix

    function automatic logic [PIX_W-1:0] comp_of(input csc_pix_s p, input int c);
        logic [PIX_W-1:0] v;
        case (c)
            0: v = p.c0;
            1: v = p.c1;
            2: v = p.c2;
            default: v = p.c3;
        endcase
        return v;
    endfunction : comp_of

    // Signed dot product of one matrix row with the unsigned input components
    function automatic logic signed [19:0] row_sum(input logic [NUM_COMP*COEF_W-1:0] row,
                                                  input csc_pix_s p);
        logic signed [19:0] acc;
        acc = '0;
        for (int c = 0; c < NUM_COMP; c++) begin
            acc = acc + 20'(signed'(row[c*COEF_W +: COEF_W])) *
                  20'(signed'({1'b0, comp_of(p, c)})); // RQ2
        end
        return acc;
    endfunction : row_sum

    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;

    // Zero wait-state slave
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = 1'b0;
    assign apb_rsp.prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            color_convert_on_r <= CTL_RST[EN_POS]; // RQ6
        end else if (wr_en && apb_req.paddr == CTL_OFS) begin
            color_convert_on_r <= apb_req.pwdata[EN_POS]; // RQ1
        end
    end

    generate
        for (genvar r = 0; r < NUM_COMP; r++) begin : g_row
            for (genvar h = 0; h < 2; h++) begin : g_half
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        coef_r[r][2*h] <= PAIR_RST[7:0]; // RQ6
                        coef_r[r][2*h+1] <= PAIR_RST[15:8]; // RQ6
                    end else if (wr_en && pair_index(apb_req.paddr) == 4'(2*r+h)) begin // RQ4
                        coef_r[r][2*h] <= apb_req.pwdata[LO_LSB +: COEF_W]; // RQ3 RQ5
                        coef_r[r][2*h+1] <= apb_req.pwdata[HI_LSB +: COEF_W]; // RQ3 RQ5
                    end
                end
            end
        end
    endgenerate

    // Read mux, upper bits always zero
    assign rd_pair = pair_index(apb_req.paddr);

    always_comb begin
        rd_word = 32'h0000_0000; // RQ7
        if (apb_req.paddr == CTL_OFS) begin
            rd_word[EN_POS] = color_convert_on_r;
        end else if (rd_pair != 4'(NUM_PAIR)) begin
            rd_word[HI_LSB +: COEF_W] = coef_r[rd_pair[2:1]][{rd_pair[0], 1'b1}]; // RQ3 RQ5
            rd_word[LO_LSB +: COEF_W] = coef_r[rd_pair[2:1]][{rd_pair[0], 1'b0}]; // RQ3 RQ5
        end
    end

    // Read data captured in setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata_r <= rd_word;
        end
    end

    // Combinational matrix product, one row per output component
    generate
        for (genvar r = 0; r < NUM_COMP; r++) begin : g_dot
            assign conv_c[r] = clamp_pix(row_sum({coef_r[r][3], coef_r[r][2], coef_r[r][1],
                                                  coef_r[r][0]}, pix_in)); // RQ2 RQ8
        end
    endgenerate

    // One-cycle multiply stage, stalls when the buffer is full
    assign stage_ready = !res_valid_r || buf_in_ready;
    assign pix_in_ready = stage_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid_r <= 1'b0;
        end else if (stage_ready) begin
            res_valid_r <= pix_in_valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_r <= '0;
        end else if (stage_ready && pix_in_valid) begin
            if (!color_convert_on_r) begin
                res_r <= pix_in; // RQ1 RQ8
            end else begin
                res_r <= {conv_c[3], conv_c[2], conv_c[1], conv_c[0]}; // RQ8
            end
        end
    end

    csc_skid_buf u_buf (
        .pclk(pclk),
        .presetn(presetn),
        .in_data(res_r),
        .in_valid(res_valid_r),
        .in_ready(buf_in_ready),
        .out_data(pix_out),
        .out_valid(pix_out_valid),
        .out_ready(pix_out_ready)
    );
endmodule : csc_matrix

// ---- verilog/csc_skid_buf.sv ----
`timescale 1ns/1ps
module csc_skid_buf
    import csc_pkg::*;
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire csc_pkg::csc_pix_s in_data, // Filling data
    input wire logic in_valid, // Filling valid
    output logic in_ready, // Room for a word
    output csc_pkg::csc_pix_s out_data, // Draining data
    output logic out_valid, // Word available
    input wire logic out_ready // Drain accepts
);
    import csc_pkg::*;

    csc_pix_s mem_r [BUF_DEPTH];
    logic wp_r;
    logic rp_r;
    logic [1:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = (cnt_r != 2'(BUF_DEPTH));
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + 2'(push) - 2'(pop);
        end
    end
endmodule : csc_skid_buf
